// ### hw/acmpc_top.sv
// Control, status and edge logic around the analog comparator.
//
// Summary of operation
// - Keeps running and can wake in wait.
// - Keeps running and can wake in deep stop.
// - Settings survive deep stop; reset clears them.
// - Debug mode does not alter operation.
// - Interrupt on rising, falling or both edges.
// - Optional inversion of the comparator output.
// - Six-bit code picks one of 64 levels.
// - DAC reference is supply or bandgap.
// - Up to four selectable comparator inputs.
// - Edge sets flag; write zero clears it.
// - Output bit reads zero while disabled.
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`default_nettype none
module acmpc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic comparator_raw,
  output acmpc_pkg::acmpc_analog_t analog_ctrl,
  output logic comparator_pin_out,
  output logic comparator_irq
);
  // Stored registers; each is one byte in the low lane of its word.
  logic [7:0] cs_q;
  logic [7:0] c0_q;
  logic [7:0] c1_q;
  logic [7:0] c2_q;
  // Synchronised and filtered comparator output, before inversion.
  logic cmp_sync;
  // Output after the optional inversion.
  logic cmp_cond;
  // Last conditioned output seen, kept for edge detection.
  logic prev_q;
  // One-cycle pulse when the selected edge occurs.
  logic edge_hit;
  // Write access phase with the low byte lane strobed.
  logic wr_acc;
  // Read setup cycle; read data is captured here.
  logic rd_hit;
  // Decoded fields of the control and status register.
  logic [1:0] edge_sensitivity_select;
  logic comparator_enable;
  logic comparator_irq_enable;
  logic comparator_event_flag;
  // Conditioned output as software reads it; zero while disabled.
  logic comparator_output_state;

  assign comparator_enable = cs_q[acmpc_pkg::ACMPC_CS_EN];
  assign comparator_irq_enable = cs_q[acmpc_pkg::ACMPC_CS_IE];
  assign comparator_event_flag = cs_q[acmpc_pkg::ACMPC_CS_FLAG];
  assign edge_sensitivity_select = cs_q[1:0];

  // Zero-wait APB slave; every access completes in its access phase.
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign wr_acc = psel & penable & pwrite & pstrb[0];

  // The raw output comes from the analog domain and must be synchronised.
  // The chain adds about four cycles to every change, so pulses shorter
  // than two cycles may be lost; that is the price of metastability safety.
  acmpc_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(comparator_raw),
    .sync_out(cmp_sync)
  );

  // Inversion happens before edge detection and reporting.
  assign cmp_cond = cmp_sync ^ c2_q[acmpc_pkg::ACMPC_C2_INV];

  // Output state is forced to zero while the comparator is off.
  assign comparator_output_state = comparator_enable & cmp_cond;

  // Previous value tracker; held at zero while disabled so that enabling
  // with a high output counts as a rising edge, as the bit itself rises.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= comparator_output_state;
    end
  end

  // Edge selection by sensitivity mode.
  always_comb begin
    edge_hit = 1'b0;
    unique case (edge_sensitivity_select)
      // Rising edges only.
      acmpc_pkg::ACMPC_MOD_RISE: begin
        edge_hit = comparator_output_state & ~prev_q;
      end
      // Either edge.
      acmpc_pkg::ACMPC_MOD_BOTH: begin
        edge_hit = comparator_output_state ^ prev_q;
      end
      // Falling edges only; two codes share this meaning.
      acmpc_pkg::ACMPC_MOD_FALL, acmpc_pkg::ACMPC_MOD_FALL2: begin
        edge_hit = ~comparator_output_state & prev_q;
      end
    endcase
    // Events count only while the comparator is enabled.
    edge_hit = edge_hit & comparator_enable;
  end

  // Control and status register. There is no low-power or debug input:
  // the block simply keeps clocking, so nothing freezes.
  // Bits 5 and 3 are not plain storage: the flag has its own set and
  // clear rules, and the output bit is read-only and never stored.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_q <= acmpc_pkg::ACMPC_RST_REG;
    end else begin
      if (wr_acc && paddr == acmpc_pkg::ACMPC_OFF_CS) begin
        cs_q[7:6] <= pwdata[7:6];
        cs_q[4] <= pwdata[4];
        cs_q[2:0] <= pwdata[2:0];
        // Writing zero clears, writing one keeps.
        if (!pwdata[acmpc_pkg::ACMPC_CS_FLAG]) begin
          cs_q[acmpc_pkg::ACMPC_CS_FLAG] <= 1'b0;
        end
      end
      // A new edge wins over a clear in the same cycle.
      if (edge_hit) begin
        cs_q[acmpc_pkg::ACMPC_CS_FLAG] <= 1'b1;
      end
    end
  end

  // Input selection register.
  // Unused bits of the input selection are kept at zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c0_q <= acmpc_pkg::ACMPC_RST_REG;
    end else if (wr_acc && paddr == acmpc_pkg::ACMPC_OFF_C0) begin
      c0_q <= {2'h0, pwdata[5:4], 2'h0, pwdata[1:0]};
    end
  end

  // DAC control register: enable, reference and level.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c1_q <= acmpc_pkg::ACMPC_RST_REG;
    end else if (wr_acc && paddr == acmpc_pkg::ACMPC_OFF_C1) begin
      c1_q <= pwdata[7:0];
    end
  end

  // Output conditioning register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c2_q <= acmpc_pkg::ACMPC_RST_REG;
    end else if (wr_acc && paddr == acmpc_pkg::ACMPC_OFF_C2) begin
      c2_q <= {7'h00, pwdata[acmpc_pkg::ACMPC_C2_INV]};
    end
  end

  // Read data is registered in the setup cycle, ready for the access phase.
  // Only a read setup loads prdata, so it stands through the access phase
  // and until the next read.
  always_comb begin
    rd_hit = psel & ~penable & ~pwrite;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Cleared on reset so no stale value is shown.
      prdata <= 32'h0000_0000;
    end else if (rd_hit) begin
      // Only the low byte lane carries data; upper bits read zero.
      unique case (paddr)
        acmpc_pkg::ACMPC_OFF_CS: begin
          prdata <= {24'h000000, cs_q[7:4], comparator_output_state,
                     cs_q[2:0]};
        end
        acmpc_pkg::ACMPC_OFF_C0: begin
          prdata <= {24'h000000, c0_q};
        end
        acmpc_pkg::ACMPC_OFF_C1: begin
          prdata <= {24'h000000, c1_q};
        end
        acmpc_pkg::ACMPC_OFF_C2: begin
          prdata <= {24'h000000, c2_q};
        end
        default: begin
          // Unmapped addresses read as zero.
          prdata <= 32'h0000_0000;
        end
      endcase
    end
  end

  // Interrupt request level; used as the wake source too.
  // It stays high until software clears the flag or the enable.
  assign comparator_irq = comparator_event_flag & comparator_irq_enable;

  // Pin output is gated by its own enable. Powering down an unused DAC is
  // left to software through its enable bit.
  assign comparator_pin_out = comparator_output_state &
                              cs_q[acmpc_pkg::ACMPC_CS_OPE];

  // Analog controls go straight from the registers.
  // Hysteresis and pin enable pass through untouched.
  always_comb begin
    analog_ctrl.comparator_enable = comparator_enable;
    analog_ctrl.hyst_high = cs_q[acmpc_pkg::ACMPC_CS_HYST];
    analog_ctrl.pin_out_enable = cs_q[acmpc_pkg::ACMPC_CS_OPE];
    analog_ctrl.pos_input_sel = c0_q[5:4];
    analog_ctrl.neg_input_sel = c0_q[1:0];
    analog_ctrl.dac_enable = c1_q[acmpc_pkg::ACMPC_C1_DACEN];
    analog_ctrl.dac_ref_bandgap = c1_q[acmpc_pkg::ACMPC_C1_REFSEL];
    analog_ctrl.dac_level = c1_q[5:0];
  end
endmodule : acmpc_top
`default_nettype wire

// ### hw/acmpc_pkg.sv
// Package with register map, field layout and types of the comparator control.
`default_nettype none
package acmpc_pkg;
  // Register byte offsets on the APB.
  localparam logic [11:0] ACMPC_OFF_CS = 12'h000;
  localparam logic [11:0] ACMPC_OFF_C0 = 12'h004;
  localparam logic [11:0] ACMPC_OFF_C1 = 12'h008;
  localparam logic [11:0] ACMPC_OFF_C2 = 12'h00c;
  // Control and status field positions.
  localparam int ACMPC_CS_EN = 7;
  localparam int ACMPC_CS_HYST = 6;
  localparam int ACMPC_CS_FLAG = 5;
  localparam int ACMPC_CS_IE = 4;
  localparam int ACMPC_CS_OUT = 3;
  localparam int ACMPC_CS_OPE = 2;
  // Control 0 fields: positive input select [5:4], negative input [1:0].
  localparam int ACMPC_C0_PSEL_LSB = 4;
  localparam int ACMPC_C0_NSEL_LSB = 0;
  // Control 1 fields: DAC enable 7, reference select 6, level [5:0].
  localparam int ACMPC_C1_DACEN = 7;
  localparam int ACMPC_C1_REFSEL = 6;
  // Control 2 fields: output invert 0.
  localparam int ACMPC_C2_INV = 0;
  // Values after reset.
  localparam logic [7:0] ACMPC_RST_REG = 8'h00;
  // Edge sensitivity encodings.
  localparam logic [1:0] ACMPC_MOD_FALL = 2'h0;
  localparam logic [1:0] ACMPC_MOD_RISE = 2'h1;
  localparam logic [1:0] ACMPC_MOD_FALL2 = 2'h2;
  localparam logic [1:0] ACMPC_MOD_BOTH = 2'h3;
  // Analog control bundle driven to the comparator macro.
  typedef struct packed {
    logic comparator_enable;
    logic hyst_high;
    logic pin_out_enable;
    logic [1:0] pos_input_sel;
    logic [1:0] neg_input_sel;
    logic dac_enable;
    logic dac_ref_bandgap;
    logic [5:0] dac_level;
  } acmpc_analog_t;
endpackage : acmpc_pkg
`default_nettype wire

// ### hw/acmpc_sync.sv
// Three-stage synchroniser with agreement filter for the comparator output.
`default_nettype none
module acmpc_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic async_in,
  output logic sync_out
);
  // Stage one is read only by stage two to keep metastability contained.
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // Shift chain; output changes once stages two and three agree.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        sync_out <= s3_q;
      end
    end
  end
endmodule : acmpc_sync
`default_nettype wire

// ### verif/acmpc_sva.sv
// Checker for the ports of the comparator control block.
`default_nettype none
module acmpc_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire acmpc_pkg::acmpc_analog_t analog_ctrl,
  input wire logic comparator_pin_out,
  input wire logic comparator_irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // A write that lands; a cleared byte lane zero means the write is refused.
  wire logic wr = psel && penable && pwrite && pstrb[0];
  AST_RST_ZERO: assert property ($rose(presetn) |->
    analog_ctrl == '0 && !comparator_irq) else $error("Reset not clean.");
  AST_OUT_OFF: assert property (!analog_ctrl.comparator_enable |->
    !comparator_pin_out) else $error("Output seen while disabled.");
  AST_PIN_GATE: assert property (!analog_ctrl.pin_out_enable |->
    !comparator_pin_out) else $error("Pin driven while gated.");
  AST_HOLD: assert property (!wr |=> $stable(analog_ctrl))
    else $error("Settings moved without a write.");
  AST_C0: assert property (wr && paddr == acmpc_pkg::ACMPC_OFF_C0 |=>
    {analog_ctrl.pos_input_sel, analog_ctrl.neg_input_sel} ==
    {$past(pwdata[5:4]), $past(pwdata[1:0])})
    else $error("Bad input select.");
  AST_C1: assert property (wr && paddr == acmpc_pkg::ACMPC_OFF_C1
    |=> {analog_ctrl.dac_enable, analog_ctrl.dac_ref_bandgap,
    analog_ctrl.dac_level} == $past(pwdata[7:0])) else $error("Bad DAC set.");
  AST_EN: assert property (wr && paddr == acmpc_pkg::ACMPC_OFF_CS |=>
    analog_ctrl.comparator_enable == $past(pwdata[7]))
    else $error("Bad enable.");
  AST_RD_HOLD: assert property (!(psel && !penable)
    |=> $stable(prdata)) else $error("Read data moved outside a read.");
endmodule : acmpc_sva
bind acmpc_top acmpc_sva i_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .analog_ctrl(analog_ctrl),
  .comparator_pin_out(comparator_pin_out), .comparator_irq(comparator_irq));
`default_nettype wire

// ### verif/acmpc_top_tb.sv
// Self-checking bench for the comparator control block.
`default_nettype none
module acmpc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, raw = 1'b0, pready, pslverr, pin, irq;
  logic [11:0] paddr = 12'h000;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] pwdata = 32'h0, prdata, rd, d;
  acmpc_pkg::acmpc_analog_t ctrl;
  // Model state: readable mask of control registers 0 to 2 (entry 0 unused), and the expected flag.
  int msk[4] = '{32'h0, 32'h33, 32'hff, 32'h01};
  int miscompares = 0, checks_done = 0, mode, inv, c1, fl, cs;
  acmpc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .comparator_raw(raw), .analog_ctrl(ctrl), .comparator_pin_out(pin),
    .comparator_irq(irq));
  initial forever #2 pclk = ~pclk;
  // Ends the run; also reached from the watchdog.
  task automatic print_verdict();
    if (miscompares == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  // One APB transfer; read data is taken at the edge that sees pready.
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] dd, input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dd;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // The watchdog is far beyond the roughly 400 cycles the tests need.
  initial begin
    #100000;
    miscompares++;
    print_verdict();
  end
  initial begin
    void'($urandom(45336));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, and an unmapped word which reads zero.
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0, 4'hf);
      chk(32'h0, rd);
    end
    // Random settings; a write without lane zero must be ignored.
    for (int i = 1; i < 4; i++) begin
      d = $urandom;
      apb(1'b1, 12'(4 * i), d, 4'hf);
      apb(1'b1, 12'(4 * i), ~d, 4'he);
      apb(1'b0, 12'(4 * i), 32'h0, 4'hf);
      chk(d & msk[i], rd);
    end
    // The DAC is not used as an input below, so software powers it down.
    apb(1'b1, acmpc_pkg::ACMPC_OFF_C1, 32'h0, 4'hf);
    // Every edge mode with and without inversion, interrupt enabled.
    for (int m = 0; m < 8; m++) begin
      mode = m % 4;
      inv = m / 4;
      raw <= 1'b0;
      apb(1'b1, acmpc_pkg::ACMPC_OFF_C2, 32'(inv), 4'hf);
      cs = 32'h94 | mode;
      apb(1'b1, acmpc_pkg::ACMPC_OFF_CS, 32'(cs), 4'hf);
      repeat (10) @(posedge pclk);
      apb(1'b1, acmpc_pkg::ACMPC_OFF_CS, 32'(cs), 4'hf);
      raw <= 1'b1;
      repeat (10) @(posedge pclk);
      c1 = 1 - inv;
      fl = (mode == 1) ? c1 : (mode == 3) ? 1 : inv;
      // Writing one to the flag must leave it as it is.
      apb(1'b1, acmpc_pkg::ACMPC_OFF_CS, 32'(cs | 32'h20), 4'hf);
      apb(1'b0, acmpc_pkg::ACMPC_OFF_CS, 32'h0, 4'hf);
      chk(32'(cs | fl << 5 | c1 << 3), rd);
      chk(32'(fl), {31'h0, irq});
      chk(32'(c1), {31'h0, pin});
      apb(1'b1, acmpc_pkg::ACMPC_OFF_CS, 32'(cs), 4'hf);
      repeat (2) @(posedge pclk);
      chk(32'h0, {31'h0, irq});
    end
    // Disabled with a high conditioned output: bit and pin must stay low.
    apb(1'b1, acmpc_pkg::ACMPC_OFF_C2, 32'h0, 4'hf);
    apb(1'b1, acmpc_pkg::ACMPC_OFF_CS, 32'h05, 4'hf);
    apb(1'b0, acmpc_pkg::ACMPC_OFF_CS, 32'h0, 4'hf);
    chk(32'h05, rd);
    chk(32'h0, {31'h0, pin});
    // A reset in mid-run returns settings to zero.
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0, 4'hf);
      chk(32'h0, rd);
    end
    print_verdict();
  end
endmodule : acmpc_top_tb
`default_nettype wire
